// file: hw/coproc_memory_decode_arbiter.sv
// Memory decode, shared-RAM arbitration and wait logic for the coprocessor.
// Assumes controller inputs arrive asynchronously and are synchronised here.
`timescale 1ns/10ps
`include "coproc_consts.svh"
module coproc_memory_decode_arbiter (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Build option: ROM wait enable
    input wire logic rom_wait_enable_in,
    // Coprocessor bus
    input wire logic [`ADDR_W-1:0] addr_in,
    input wire logic mem_request_n_in,
    input wire logic io_request_n_in,
    input wire logic write_n_in,
    // Controller side, asynchronous
    input wire logic controller_shared_request_in,
    input wire logic controller_priority_override_in,
    // Local chip selects
    output logic [`ROM_CNT-1:0] rom_ce_n_out,
    output logic [`RAM_CNT-1:0] ram_cs_n_out,
    // Shared RAM control
    output logic coproc_shared_select_n_out,
    output logic coproc_shared_mem_request_n_out,
    output logic shared_data_bus_enable_n_out,
    output logic delayed_write_strobe_n_out,
    output logic controller_grant_n_out,
    output logic controller_grant_out,
    output logic controller_steer_out,
    output logic coproc_on_bus_delayed_out,
    output logic coproc_on_bus_delayed_n_out,
    // Processor wait, active low
    output logic wait_n_out,
    output logic program_store_stall_n_out
);
    // Controller input synchronisers
    logic req_meta_r;
    logic req_sync_r;
    logic prio_meta_r;
    logic prio_sync_r;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            req_meta_r <= 1'b0;
            req_sync_r <= 1'b0;
            prio_meta_r <= 1'b0;
            prio_sync_r <= 1'b0;
        end else begin
            req_meta_r <= controller_shared_request_in;
            req_sync_r <= req_meta_r;
            prio_meta_r <= controller_priority_override_in;
            prio_sync_r <= prio_meta_r;
        end
    end

    // Shared window decode
    wire shared_addr;
    wire shared_sel;
    wire cop_req;
    wire ram_access;
    assign shared_addr = addr_in[`ADDR_MSB] &&
        (addr_in >= `SHARED_BASE);
    assign shared_sel = addr_in[`ADDR_MSB] && io_request_n_in;
    assign coproc_shared_select_n_out = !shared_sel;
    assign cop_req = shared_sel && shared_addr && !mem_request_n_in;
    assign coproc_shared_mem_request_n_out = !cop_req;

    // Arbiter state: current owner and last user
    coproc_pkg::owner_t owner_r;
    coproc_pkg::owner_t owner_nxt;
    logic grant_flag_r;
    wire ctrl_req;
    assign ctrl_req = req_sync_r;
    // Override, hold, exclusive request, tie to last user
    always_comb begin
        owner_nxt = owner_r;
        if (prio_sync_r) begin
            owner_nxt = coproc_pkg::OWNER_CONTROLLER;
        end else if (owner_r == coproc_pkg::OWNER_CONTROLLER && ctrl_req) begin
            owner_nxt = owner_r;
        end else if (owner_r == coproc_pkg::OWNER_COPROC && shared_sel &&
            grant_flag_r) begin
            owner_nxt = owner_r;
        end else if (ctrl_req && !cop_req) begin
            owner_nxt = coproc_pkg::OWNER_CONTROLLER;
        end else if (cop_req && !ctrl_req) begin
            owner_nxt = coproc_pkg::OWNER_COPROC;
        end else begin
            owner_nxt = owner_r;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            owner_r <= coproc_pkg::OWNER_CONTROLLER;
        end else begin
            owner_r <= owner_nxt;
        end
    end

    // Controller grant is combinational so eviction acts at once
    wire ctrl_grant;
    assign ctrl_grant = (owner_r == coproc_pkg::OWNER_CONTROLLER) ||
        prio_sync_r;
    assign controller_grant_n_out = !ctrl_grant;
    assign controller_grant_out = ctrl_grant;
    assign controller_steer_out = ctrl_grant;

    // Grant flag: set on the clock, dropped combinationally by grant
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            grant_flag_r <= 1'b0;
        end else begin
            grant_flag_r <= !ctrl_grant;
        end
    end
    wire grant_flag;
    assign grant_flag = grant_flag_r && !ctrl_grant;
    assign coproc_on_bus_delayed_out = grant_flag;
    assign coproc_on_bus_delayed_n_out = !grant_flag;

    // Shared data path enables
    wire data_en;
    assign data_en = cop_req && grant_flag;
    assign shared_data_bus_enable_n_out = !data_en;
    assign delayed_write_strobe_n_out = !(data_en && !write_n_in);

    // Local decode
    local_mem_decode u_decode (
        .addr_in(addr_in),
        .mem_request_n_in(mem_request_n_in),
        .rom_ce_n_out(rom_ce_n_out),
        .ram_cs_n_out(ram_cs_n_out),
        .ram_access_out(ram_access)
    );

    // ROM wait generator; fast regions skip the wait
    wire fast_access;
    assign fast_access = ram_access || shared_sel;
    rom_wait_gen u_wait (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .mem_request_n_in(mem_request_n_in),
        .fast_access_in(fast_access),
        .wait_enable_in(rom_wait_enable_in),
        .program_store_stall_n_out(program_store_stall_n_out)
    );

    // Either source stalls the processor
    assign wait_n_out = program_store_stall_n_out &&
        !(cop_req && !grant_flag);

    // Checks share the board clock and the reset
    default clocking cb_board @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // Controller lets go, then the flag rises one edge later
    sequence s_grant_release;
        $fell(controller_grant_out);
    endsequence
    sequence s_flag_rise;
        !grant_flag ##1 (grant_flag || controller_grant_out);
    endsequence

    // Override wins at once, whatever the coprocessor was doing
    a_ovr_evicts: assert property (
        prio_sync_r |-> controller_grant_out && coproc_on_bus_delayed_n_out)
        else $error("override did not evict coprocessor");
    // A pending shared request without the flag stalls the processor
    a_stall_no_grant: assert property (
        (cop_req && !grant_flag) |-> !wait_n_out)
        else $error("no wait while shared grant pending");
    // Lone requesters win on the next edge; the controller only once grant_flag_r is clear
    a_ctrl_alone: assert property (
        (ctrl_req && !cop_req && !grant_flag_r) |=> controller_grant_out)
        else $error("controller alone not granted");
    a_cop_alone: assert property (
        (cop_req && !ctrl_req && !prio_sync_r) |=>
        (owner_r == coproc_pkg::OWNER_COPROC))
        else $error("coprocessor alone not granted");
    // Flag is late to rise but never late to fall
    a_flag_sync: assert property (
        s_grant_release |-> s_flag_rise)
        else $error("grant flag timing wrong");
    a_flag_drop: assert property (
        controller_grant_out |-> !coproc_on_bus_delayed_out)
        else $error("grant flag up beside controller grant");
    // Data path opens only for a granted coprocessor access
    a_enable_grant: assert property (
        !shared_data_bus_enable_n_out |->
        !controller_grant_out && !coproc_shared_mem_request_n_out)
        else $error("data enable without grant");
    a_write_gate: assert property (
        !delayed_write_strobe_n_out |->
        !write_n_in && !shared_data_bus_enable_n_out)
        else $error("write strobe without enable");
    // Contention without the override never moves the owner; the holder keeps it
    a_hold_ctrl: assert property (
        (controller_grant_out && ctrl_req) |=> controller_grant_out)
        else $error("controller grant dropped early");
    a_tie_last: assert property (
        (cop_req && ctrl_req && !prio_sync_r) |=> $stable(owner_r))
        else $error("contention moved the shared RAM");
    // Steering follows the grant, and the off-board copy is its inverse
    a_steer_copy: assert property (
        controller_steer_out == controller_grant_out &&
        controller_grant_n_out != controller_grant_out)
        else $error("steer or inverted grant wrong");
    a_reset_owner: assert property (
        $rose(rst_n_in) |-> controller_grant_out &&
        !coproc_on_bus_delayed_out)
        else $error("reset did not hand the bus to the controller");
    // Local decode: at most one chip, and only inside a memory request
    a_rom_onehot: assert property (
        $onehot0({~rom_ce_n_out, ~ram_cs_n_out}))
        else $error("more than one local chip select");
    a_local_quiet: assert property (
        mem_request_n_in |-> (&rom_ce_n_out) && (&ram_cs_n_out))
        else $error("local chip select without memory request");
    // The lower half never reaches the shared RAM
    a_local_private: assert property (
        !addr_in[`ADDR_MSB] |-> coproc_shared_select_n_out &&
        coproc_shared_mem_request_n_out)
        else $error("low half reached shared RAM");
    a_request_decode: assert property (
        !coproc_shared_mem_request_n_out |-> !mem_request_n_in &&
        !coproc_shared_select_n_out)
        else $error("shared request without strobe and select");
endmodule

// file: hw/coproc_consts.svh
// Constants for the coprocessor memory decode and shared-memory arbiter.
// Assumes a 16-bit address bus and active-low processor strobes.
`ifndef COPROC_CONSTS_SVH
`define COPROC_CONSTS_SVH

`define ADDR_W 16
`define ROM_CNT 7
`define RAM_CNT 2
`define ROM_SEL_HI 15
`define ROM_SEL_LO 12
`define RAM_SEL_LO 11
`define ROM_LAST_BLOCK 4'h6
`define RAM_PATTERN_HI 4'b0111
`define SHARED_BASE 16'h9000
`define ADDR_MSB 15

`endif

// file: hw/coproc_pkg.sv
// Types for the coprocessor memory decode and arbiter.
// Assumes the constants header is included by the modules that need it.
package coproc_pkg;
    // Who used the shared RAM last, or holds it now
    typedef enum logic {
        OWNER_CONTROLLER,
        OWNER_COPROC
    } owner_t;
endpackage

// file: hw/local_mem_decode.sv
// Local ROM and scratch RAM chip-select decoder.
// Assumes the address and memory request come from the same clock domain.
`timescale 1ns/10ps
`include "coproc_consts.svh"
module local_mem_decode (
    // Processor side
    input wire logic [`ADDR_W-1:0] addr_in,
    input wire logic mem_request_n_in,
    // Chip selects, active low; RAM access flag, active high
    output logic [`ROM_CNT-1:0] rom_ce_n_out,
    output logic [`RAM_CNT-1:0] ram_cs_n_out,
    output logic ram_access_out
);
    // Decoded fields
    wire [3:0] block_sel;
    wire rom_hit;
    wire ram_hit;
    assign block_sel = addr_in[`ROM_SEL_HI:`ROM_SEL_LO];
    assign rom_hit = !mem_request_n_in &&
        (block_sel <= `ROM_LAST_BLOCK);
    assign ram_hit = !mem_request_n_in &&
        (block_sel == `RAM_PATTERN_HI);

    // One-hot selects; only one enable can be low at a time
    always_comb begin
        rom_ce_n_out = '1;
        ram_cs_n_out = '1;
        if (rom_hit) begin
            rom_ce_n_out[block_sel[2:0]] = 1'b0;
        end
        if (ram_hit) begin
            ram_cs_n_out[addr_in[`RAM_SEL_LO]] = 1'b0;
        end
    end
    assign ram_access_out = ram_hit;
    // No clock here, so the one-hot checks sit in the parent
endmodule

// file: hw/rom_wait_gen.sv
// Two-stage ROM wait-state generator.
// Assumes strobes are already synchronised to the board clock.
`timescale 1ns/10ps
module rom_wait_gen (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Access qualifiers
    input wire logic mem_request_n_in,
    input wire logic fast_access_in,
    input wire logic wait_enable_in,
    // Wait output, active low
    output logic program_store_stall_n_out
);
    logic stage1_r;
    logic stage2_r;
    // Stage one follows the request; stage two lags it one edge
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            stage1_r <= 1'b0;
            stage2_r <= 1'b0;
        end else begin
            stage1_r <= !mem_request_n_in;
            stage2_r <= stage1_r && !fast_access_in;
        end
    end
    // Wait is the window where stage one is set but stage two not yet
    assign program_store_stall_n_out = !(wait_enable_in && stage1_r &&
        !stage2_r && !fast_access_in && !mem_request_n_in);

    // Request newly low, then a ROM cycle still under way one edge later
    sequence s_rom_entry;
        (!mem_request_n_in && !stage1_r) ##1
        (!mem_request_n_in && !fast_access_in && wait_enable_in);
    endsequence
    a_wait_starts: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        s_rom_entry |-> !program_store_stall_n_out)
        else $error("rom wait missing on first edge");
    a_wait_one_cycle: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        !program_store_stall_n_out |=> program_store_stall_n_out)
        else $error("rom wait longer than one cycle");
    a_wait_idle_after: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        $rose(mem_request_n_in) |-> program_store_stall_n_out [*2])
        else $error("rom wait after request end");
    // Fast regions and a disabled option never stall
    a_fast_no_wait: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        fast_access_in |-> program_store_stall_n_out)
        else $error("rom wait on a fast region");
    a_wait_disabled: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        !wait_enable_in |-> program_store_stall_n_out)
        else $error("rom wait while disabled");
endmodule

// file: verification/controller_model.sv
// Controller processor model: shared request and priority override.
// Assumes the bench commands it; outputs change just after rising edges.
`timescale 1ns/10ps
module controller_model (
    // Clock and commands from the bench
    input wire logic clk_in,
    input wire logic want_in,
    input wire logic force_in,
    // Lines into the arbiter
    output logic shared_request_out,
    output logic priority_override_out
);
    // Idle until commanded
    initial begin
        shared_request_out = 1'b0;
        priority_override_out = 1'b0;
    end
    // Request held for as long as access is wanted
    always @(posedge clk_in) begin
        shared_request_out <= want_in;
        priority_override_out <= force_in & want_in;
    end
endmodule

// file: verification/test_coproc_memory_decode_arbiter.sv
// Self-checking bench for the memory decode and shared-RAM arbiter.
// Assumes the controller model drives the asynchronous controller lines.
`timescale 1ns/10ps
module test_coproc_memory_decode_arbiter;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic wen = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic mreq_n = 1'b1;
    logic wr_n = 1'b1;
    logic iorq_n = 1'b1;
    logic want = 1'b0;
    logic frc = 1'b0;
    logic creq, covr, sel_n, smreq_n, smen_n, wrd_n, g_n, g, steer;
    logic cob, cob_n, wait_n, stall_n;
    logic [6:0] ce_n;
    logic [1:0] cs_n;
    logic [19:0] obs;
    logic [39:0] q[$];
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    integer seed = 32'h9784_de7a;

    controller_model ctl (.clk_in(clk_in), .want_in(want), .force_in(frc),
        .shared_request_out(creq), .priority_override_out(covr));
    coproc_memory_decode_arbiter DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .rom_wait_enable_in(wen), .addr_in(addr), .mem_request_n_in(mreq_n),
        .io_request_n_in(iorq_n), .write_n_in(wr_n),
        .controller_shared_request_in(creq),
        .controller_priority_override_in(covr),
        .rom_ce_n_out(ce_n), .ram_cs_n_out(cs_n),
        .coproc_shared_select_n_out(sel_n),
        .coproc_shared_mem_request_n_out(smreq_n),
        .shared_data_bus_enable_n_out(smen_n),
        .delayed_write_strobe_n_out(wrd_n), .controller_grant_n_out(g_n),
        .controller_grant_out(g), .controller_steer_out(steer),
        .coproc_on_bus_delayed_out(cob),
        .coproc_on_bus_delayed_n_out(cob_n), .wait_n_out(wait_n),
        .program_store_stall_n_out(stall_n));

    // All watched outputs in one vector; notes carry a mask
    assign obs = {ce_n, cs_n, sel_n, smreq_n, smen_n, wrd_n, g_n, g, steer,
        cob, cob_n, wait_n, stall_n};

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Notes are judged 1 ns after the falling edge; inputs and registers
    // have settled there, well clear of the rising edge
    always @(negedge clk_in) begin
        logic [39:0] n;
        #1;
        cycles++;
        while (q.size() > 0) begin
            n = q.pop_front();
            checks_done++;
            if ((obs & n[39:20]) !== n[19:0]) begin
                n_fail++;
                $display("wrong value at %0t: got %h expected %h", $time,
                    obs & n[39:20], n[19:0]);
            end
        end
        if (cycles == 3000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic note(input logic [19:0] m, input logic [19:0] v);
        q.push_back({m, v & m});
    endtask
    task automatic cyc(input int k = 1);
        repeat (k) @(negedge clk_in);
    endtask
    task automatic dec(input logic [6:0] ce, input logic [1:0] cs);
        note(20'hF_F800, {ce, cs, 11'h000});
    endtask
    task automatic st(input logic s);
        note(20'h0_0001, {19'h0_0000, s});
    endtask
    // Coprocessor owns when c is high
    task automatic arb(input logic c);
        note(20'h0_007C, {13'h0000, c, ~c, ~c, c, ~c, 2'h0});
    endtask
    // Select, request, data enable, write strobe, then processor wait
    task automatic sh(input logic [3:0] s, input logic w);
        note(20'h0_0782, {9'h000, s, 5'h00, w, 1'b0});
    endtask
    // Bounded wait; a miss shows up in the note that follows
    task automatic wait_bit(input int b, input logic v);
        for (int i = 0; i < 20 && obs[b] !== v; i++) cyc();
    endtask
    task automatic shared(input logic go);
        logic [31:0] r;
        r = $random(seed);
        addr = go ? {4'h9 + 4'(r[30:28] % 3'h7), r[11:0]} : 16'h0000;
        mreq_n = ~go;
        wr_n = go ? r[31] : 1'b1;
    endtask

    initial begin
        logic [31:0] r;
        cyc(4);
        rst_n_in = 1'b1;
        arb(1'b0);
        st(1'b1);
        cyc();
        // Seven ROM blocks then scratch RAM, each with its wait pattern
        for (int b = 0; b < 8; b++) begin
            r = $random(seed);
            addr = {b[3:0], r[11:0]};
            mreq_n = 1'b0;
            dec(b < 7 ? ~(7'h01 << b) : 7'h7F,
                b < 7 ? 2'h3 : (r[11] ? 2'h1 : 2'h2));
            st(1'b1);
            cyc();
            st(b == 7);
            cyc();
            st(1'b1);
            cyc();
            mreq_n = 1'b1;
            dec(7'h7F, 2'h3);
            st(1'b1);
            cyc();
            st(1'b1);
            cyc();
        end
        // Wait disabled, and the gap below shared RAM selects no local chip
        wen = 1'b0;
        addr = 16'h2ABC;
        mreq_n = 1'b0;
        repeat (3) begin st(1'b1); cyc(); end
        wen = 1'b1;
        addr = 16'h8123;
        dec(7'h7F, 2'h3);
        cyc();
        mreq_n = 1'b1;
        cyc();
        // I/O cycle in the upper half leaves shared RAM alone
        addr = 16'hA000;
        iorq_n = 1'b0;
        sh(4'b1111, 1'b1);
        cyc();
        iorq_n = 1'b1;
        sh(4'b0111, 1'b1);
        cyc();
        // Coprocessor alone, then contention both ways
        shared(1'b1);
        sh(4'b0011, 1'b0);
        arb(1'b0);
        wait_bit(3, 1'b1);
        arb(1'b1);
        sh({3'b000, wr_n}, 1'b1);
        want = 1'b1;
        repeat (6) begin arb(1'b1); cyc(); end
        shared(1'b0);
        wait_bit(5, 1'b1);
        arb(1'b0);
        shared(1'b1);
        repeat (6) begin arb(1'b0); sh(4'b0011, 1'b0); cyc(); end
        want = 1'b0;
        wait_bit(3, 1'b1);
        arb(1'b1);
        shared(1'b0);
        cyc(4);
        // Tie with the coprocessor as last user
        want = 1'b1;
        shared(1'b1);
        repeat (6) begin arb(1'b1); cyc(); end
        frc = 1'b1;
        wait_bit(5, 1'b1);
        arb(1'b0);
        sh(4'b0011, 1'b0);
        cyc();
        shared(1'b0);
        cyc(4);
        frc = 1'b0;
        want = 1'b0;
        cyc(4);
        // Tie with the controller as last user; its sync lag is covered
        want = 1'b1;
        cyc(3);
        shared(1'b1);
        repeat (6) begin arb(1'b0); cyc(); end
        shared(1'b0);
        want = 1'b0;
        cyc(4);
        // Reset after the coprocessor used the bus hands it back
        shared(1'b1);
        wait_bit(3, 1'b1);
        arb(1'b1);
        shared(1'b0);
        rst_n_in = 1'b0;
        cyc(4);
        rst_n_in = 1'b1;
        arb(1'b0);
        st(1'b1);
        cyc();
        end_of_test();
    end
endmodule
